// ---- hdl/iso_engine.sv ----
// device-side isochronous IN/OUT transaction engine with Avalon-MM control
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module iso_engine
  import iso_engine_pkg::*;
(
  input  wire logic               CLK_I,
  input  wire logic               RST_I,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0]  ADDRESS_I,
  input  wire logic               READ_I,
  input  wire logic               WRITE_I,
  input  wire logic [31:0]        WRITEDATA_I,
  output logic      [31:0]        READDATA_O,
  output logic                    WAITREQUEST_O,
  // service interval boundary
  input  wire logic               SI_START_I,
  // decoded ACK TP
  input  wire logic               ACK_VALID_I,
  input  wire logic [DADDR_W-1:0] ACK_ADDR_I,
  input  wire logic [EP_W-1:0]    ACK_EP_I,
  input  wire logic               ACK_DIR_IN_I,
  input  wire logic [SEQ_W-1:0]   ACK_SEQ_I,
  input  wire logic [NUMP_W-1:0]  ACK_NUMP_I,
  input  wire logic               ACK_DEFER_I,
  input  wire logic [TT_W-1:0]    ACK_TT_I,
  // application IN data source
  input  wire logic               TX_HAVE_I,
  input  wire logic               TX_LAST_I,
  output logic                    TX_POP_O,
  // data packet header to the link
  output logic                    DP_VALID_O,
  input  wire logic               DP_READY_I,
  output logic      [SEQ_W-1:0]   DP_SEQ_O,
  output logic                    DP_LPF_O,
  output logic                    DP_ZLP_O,
  // decoded OUT data packet
  input  wire logic               OUT_VALID_I,
  input  wire logic [DADDR_W-1:0] OUT_ADDR_I,
  input  wire logic [EP_W-1:0]    OUT_EP_I,
  input  wire logic [SEQ_W-1:0]   OUT_SEQ_I,
  input  wire logic               OUT_CRC_OK_I,
  input  wire logic               OUT_ABORT_I,
  input  wire logic               OUT_MISSING_I,
  input  wire logic               OUT_LEN_OK_I,
  input  wire logic               OUT_DEFER_I,
  input  wire logic [TT_W-1:0]    OUT_TT_I,
  input  wire logic               OUT_BUF_RDY_I,
  output logic                    OUT_ACCEPT_O,
  output logic                    OUT_DISCARD_O
);

  logic [CTRL_W-1:0]  ctrl_reg;
  logic [SEQ_W-1:0]   ack_seq_reg;
  logic [SEQ_W-1:0]   tx_seq_reg;
  logic [OUTS_W-1:0]  outs_reg;
  logic [OUTS_W-1:0]  outs_next;
  logic               eoi_reg;
  tx_state_e          tx_state_reg;
  logic [SEQ_W-1:0]   out_seq_reg;
  logic               out_drop_reg;
  logic [CNT_W-1:0]   acc_cnt_reg;
  logic [CNT_W-1:0]   dis_cnt_reg;
  logic               ack_take;
  logic               dp_done;
  logic               out_mine;
  logic               out_err;
  logic               bus_rd_pick;
  logic               bus_wr_take;
  logic [31:0]        rd_mux;

  function automatic logic addr_ep_match(input logic [DADDR_W-1:0] a,
                                         input logic [EP_W-1:0]    e,
                                         input logic [CTRL_W-1:0]  c);
    return (a == c[CTRL_ADDR_LSB +: DADDR_W]) && (e == c[CTRL_EP_LSB +: EP_W]);
  endfunction : addr_ep_match

  // type field is only checked above base speed
  function automatic logic tt_ok(input logic [TT_W-1:0] tt, input logic gen2);
    return !gen2 || (tt == TT_ISO);
  endfunction : tt_ok

  // ---------------- Avalon-MM slave: one wait cycle per access ----------------
  assign bus_rd_pick = READ_I && WAITREQUEST_O;
  assign bus_wr_take = WRITE_I && !WAITREQUEST_O;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ADDRESS_I)
      OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_reg;
      OFS_STATUS: begin
        rd_mux[ST_INSEQ_LSB +: SEQ_W]   = tx_seq_reg;
        rd_mux[ST_OUTSEQ_LSB +: SEQ_W]  = out_seq_reg;
        rd_mux[ST_EOI]                  = eoi_reg;
        rd_mux[ST_OUTDROP]              = out_drop_reg;
        rd_mux[ST_OUTS_LSB +: OUTS_W]   = outs_reg;
        rd_mux[ST_ACKSEQ_LSB +: SEQ_W]  = ack_seq_reg;
      end
      OFS_COUNT: begin
        rd_mux[CNT_ACC_LSB +: CNT_W] = acc_cnt_reg;
        rd_mux[CNT_DIS_LSB +: CNT_W] = dis_cnt_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WAITREQUEST_O <= 1'b1;
    end else begin
      WAITREQUEST_O <= !((READ_I || WRITE_I) && WAITREQUEST_O);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      READDATA_O <= 32'h0000_0000;
    end else if (bus_rd_pick) begin
      READDATA_O <= rd_mux;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_reg <= CTRL_RESET;
    end else if (bus_wr_take && ADDRESS_I == OFS_CTRL) begin
      ctrl_reg <= WRITEDATA_I[CTRL_W-1:0];
    end
  end

  // ---------------- IN path: ACK TP validation and data packet issue ----------
  // the host side keeps pipelining within burst and interval limits
  assign ack_take = ACK_VALID_I && ACK_DIR_IN_I && ctrl_reg[CTRL_IN_EN]
                  && addr_ep_match(ACK_ADDR_I, ACK_EP_I, ctrl_reg)
                  && (ACK_SEQ_I == ack_seq_reg) && !ACK_DEFER_I
                  && tt_ok(ACK_TT_I, ctrl_reg[CTRL_GEN2]) && !eoi_reg;
  assign dp_done  = (tx_state_reg == TX_OFFER) && DP_READY_I;

  always_comb begin
    outs_next = outs_reg;
    if (ack_take) begin
      outs_next = outs_next + OUTS_W'(ACK_NUMP_I);
    end
    if (dp_done) begin
      outs_next = outs_next - OUTS_ONE;
    end
  end

  // expected sequence of the next ACK TP follows the host's pipelining
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_seq_reg <= SEQ_ZERO;
    end else if (SI_START_I) begin
      ack_seq_reg <= SEQ_ZERO;
    end else if (ack_take) begin
      ack_seq_reg <= SEQ_W'(ack_seq_reg + ACK_NUMP_I);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      outs_reg <= '0;
    end else if (SI_START_I) begin
      outs_reg <= '0;
    end else if (dp_done && DP_LPF_O) begin
      outs_reg <= '0;
    end else begin
      outs_reg <= outs_next;
    end
  end

  // end-of-interval flag: once set, every further ACK TP is dropped until the boundary
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      eoi_reg <= 1'b0;
    end else if (SI_START_I) begin
      eoi_reg <= 1'b0;
    end else if (dp_done && DP_LPF_O) begin
      eoi_reg <= 1'b1;
    end
  end

  // a boundary withdraws an offered packet; the link must not rely on its completion
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_state_reg <= TX_IDLE;
      tx_seq_reg   <= SEQ_ZERO;
      DP_VALID_O   <= 1'b0;
      DP_SEQ_O     <= SEQ_ZERO;
      DP_LPF_O     <= 1'b0;
      DP_ZLP_O     <= 1'b0;
      TX_POP_O     <= 1'b0;
    end else begin
      TX_POP_O <= 1'b0;
      if (SI_START_I) begin
        tx_state_reg <= TX_IDLE;
        tx_seq_reg   <= SEQ_ZERO;
        DP_VALID_O   <= 1'b0;
      end else begin
        unique case (tx_state_reg)
          TX_IDLE: begin
            if (outs_reg != '0 && !eoi_reg) begin
              tx_state_reg <= TX_OFFER;
              DP_VALID_O   <= 1'b1;
              // no data yet: zero-length with sequence 0, ends the interval
              DP_SEQ_O     <= TX_HAVE_I ? tx_seq_reg : SEQ_ZERO;
              DP_ZLP_O     <= !TX_HAVE_I;
              DP_LPF_O     <= TX_LAST_I || !TX_HAVE_I;
            end
          end
          TX_OFFER: begin
            if (DP_READY_I) begin
              tx_state_reg <= TX_IDLE;
              DP_VALID_O   <= 1'b0;
              tx_seq_reg   <= SEQ_W'(tx_seq_reg + SEQ_ONE);
              TX_POP_O     <= !DP_ZLP_O;
            end
          end
        endcase
      end
    end
  end

  // OUT path: validation, never any reply
  assign out_mine = OUT_VALID_I && ctrl_reg[CTRL_OUT_EN]
                  && addr_ep_match(OUT_ADDR_I, OUT_EP_I, ctrl_reg);
  assign out_err  = !OUT_CRC_OK_I || OUT_ABORT_I || OUT_MISSING_I || !OUT_LEN_OK_I
                  || OUT_DEFER_I || !tt_ok(OUT_TT_I, ctrl_reg[CTRL_GEN2]);

  // errored packets do not advance the sequence, so the next good one mismatches
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      out_seq_reg   <= SEQ_ZERO;
      out_drop_reg  <= 1'b0;
      OUT_ACCEPT_O  <= 1'b0;
      OUT_DISCARD_O <= 1'b0;
    end else begin
      OUT_ACCEPT_O  <= 1'b0;
      OUT_DISCARD_O <= 1'b0;
      if (SI_START_I) begin
        out_seq_reg  <= SEQ_ZERO;
        out_drop_reg <= 1'b0;
      end else if (out_mine) begin
        if (out_err) begin
          OUT_DISCARD_O <= 1'b1;
        end else if (OUT_SEQ_I != out_seq_reg || out_drop_reg) begin
          OUT_DISCARD_O <= 1'b1;
          out_drop_reg  <= ctrl_reg[CTRL_DROPREST];
        end else begin
          out_seq_reg   <= SEQ_W'(out_seq_reg + SEQ_ONE);
          OUT_ACCEPT_O  <= OUT_BUF_RDY_I;
          OUT_DISCARD_O <= !OUT_BUF_RDY_I;
        end
      end
    end
  end

  // counters wrap; software reads differences
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      acc_cnt_reg <= '0;
      dis_cnt_reg <= '0;
    end else begin
      if (OUT_ACCEPT_O) begin
        acc_cnt_reg <= CNT_W'(acc_cnt_reg + CNT_ONE);
      end
      if (OUT_DISCARD_O) begin
        dis_cnt_reg <= CNT_W'(dis_cnt_reg + CNT_ONE);
      end
    end
  end

endmodule : iso_engine
`default_nettype wire

// ---- include/iso_engine_pkg.sv ----
// shared constants for the isochronous transaction engine
package iso_engine_pkg;
  localparam int SEQ_W   = 5;
  localparam int NUMP_W  = 5;
  localparam int OUTS_W  = 6;
  localparam int DADDR_W = 7;
  localparam int EP_W    = 4;
  localparam int TT_W    = 3;
  localparam int CNT_W   = 16;
  localparam int BUS_AW  = 4;

  localparam logic [SEQ_W-1:0]  SEQ_ZERO = 5'h00;
  localparam logic [SEQ_W-1:0]  SEQ_ONE  = 5'h01;
  localparam logic [OUTS_W-1:0] OUTS_ONE = 6'h01;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
  // transfer type code for isochronous packets above base speed (arbitrary encoding)
  localparam logic [TT_W-1:0]   TT_ISO   = 3'h1;

  // register byte offsets
  localparam logic [BUS_AW-1:0] OFS_CTRL   = 4'h0;
  localparam logic [BUS_AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [BUS_AW-1:0] OFS_COUNT  = 4'h8;

  // control fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_EP_LSB   = 7;
  localparam int CTRL_IN_EN    = 11;
  localparam int CTRL_OUT_EN   = 12;
  localparam int CTRL_GEN2     = 13;
  localparam int CTRL_DROPREST = 14;
  localparam int CTRL_W        = 15;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;

  // status fields
  localparam int ST_INSEQ_LSB  = 0;
  localparam int ST_OUTSEQ_LSB = 5;
  localparam int ST_EOI        = 10;
  localparam int ST_OUTDROP    = 11;
  localparam int ST_OUTS_LSB   = 12;
  localparam int ST_ACKSEQ_LSB = 18;

  // count fields
  localparam int CNT_ACC_LSB = 0;
  localparam int CNT_DIS_LSB = 16;

  typedef enum logic {TX_IDLE, TX_OFFER} tx_state_e;
endpackage : iso_engine_pkg

// ---- tb/iso_engine_properties.sv ----
// port-level assertions for the isochronous transaction engine
`timescale 1ns/10ps
`default_nettype none
module iso_engine_properties
  import iso_engine_pkg::*;
(
  input wire logic             CLK_I,
  input wire logic             RST_I,
  input wire logic             READ_I,
  input wire logic             WRITE_I,
  input wire logic             WAITREQUEST_O,
  input wire logic             SI_START_I,
  input wire logic             DP_VALID_O,
  input wire logic             DP_READY_I,
  input wire logic             DP_LPF_O,
  input wire logic             DP_ZLP_O,
  input wire logic [SEQ_W-1:0] DP_SEQ_O,
  input wire logic             TX_POP_O,
  input wire logic             OUT_VALID_I,
  input wire logic             OUT_CRC_OK_I,
  input wire logic             OUT_LEN_OK_I,
  input wire logic             OUT_ABORT_I,
  input wire logic             OUT_MISSING_I,
  input wire logic             OUT_DEFER_I,
  input wire logic             OUT_BUF_RDY_I,
  input wire logic             OUT_ACCEPT_O,
  input wire logic             OUT_DISCARD_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wait_pulse_a: assert property (!WAITREQUEST_O |=> WAITREQUEST_O)
    else $error("wait request low too long");
  bus_answer_a: assert property ($rose(READ_I) || $rose(WRITE_I) |=> !WAITREQUEST_O)
    else $error("bus access not answered");
  dp_hold_a: assert property (DP_VALID_O && !DP_READY_I && !SI_START_I |=> DP_VALID_O
    && $stable(DP_SEQ_O) && $stable(DP_LPF_O) && $stable(DP_ZLP_O)) else $error("header moved");
  zlp_form_a: assert property (DP_VALID_O && DP_ZLP_O |-> DP_LPF_O && DP_SEQ_O == SEQ_ZERO)
    else $error("bad empty packet");
  seq_step_a: assert property (DP_VALID_O && DP_READY_I && !DP_LPF_O && !SI_START_I ##1
    !SI_START_I ##1 DP_VALID_O && !DP_ZLP_O |-> DP_SEQ_O == $past(DP_SEQ_O, 2) + SEQ_ONE)
    else $error("sequence step wrong");
  lpf_quiet_a: assert property (DP_VALID_O && DP_READY_I && DP_LPF_O |=> !DP_VALID_O [*2])
    else $error("packet after last");
  pop_cause_a: assert property (TX_POP_O |-> $past(DP_VALID_O && DP_READY_I && !DP_ZLP_O))
    else $error("pop without send");
  out_accept_a: assert property (OUT_ACCEPT_O |-> $past(OUT_VALID_I && OUT_CRC_OK_I
    && OUT_LEN_OK_I && !OUT_ABORT_I && !OUT_MISSING_I && !OUT_DEFER_I && OUT_BUF_RDY_I))
    else $error("bad packet accepted");
  out_verdict_a: assert property (OUT_ACCEPT_O || OUT_DISCARD_O |-> $past(OUT_VALID_I)
    && !(OUT_ACCEPT_O && OUT_DISCARD_O)) else $error("stray verdict");
endmodule : iso_engine_properties
`default_nettype wire

// ---- tb/iso_link_model.sv ----
// link-side receiver of offered data packet headers
`timescale 1ns/10ps
`default_nettype none
module iso_link_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       si_i,
  input  wire logic       dp_valid_i,
  input  wire logic [4:0] dp_seq_i,
  input  wire logic       dp_lpf_i,
  input  wire logic [3:0] stall_i,
  output logic            dp_ready_o,
  output logic            bad_o
);
  logic [3:0] wait_reg;
  logic [4:0] exp_reg;
  logic       done_reg;
  // takes packets after stall_i cycles and never answers them
  assign dp_ready_o = dp_valid_i && (wait_reg >= stall_i);
  // host receive side: a header out of sequence or after the last flag would be discarded
  // only headers cross this link, so payload checks have nothing to act on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exp_reg  <= 5'h00;
      done_reg <= 1'b0;
      bad_o    <= 1'b0;
    end else if (si_i) begin
      exp_reg  <= 5'h00;
      done_reg <= 1'b0;
    end else if (dp_ready_o) begin
      exp_reg  <= exp_reg + 5'h01;
      done_reg <= dp_lpf_i;
      if (dp_seq_i != exp_reg || done_reg) begin
        bad_o <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg <= 4'h0;
    end else if (!dp_valid_i || dp_ready_o) begin
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : iso_link_model
`default_nettype wire

// ---- tb/iso_engine_tb.sv ----
// self-checking bench for the isochronous transaction engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %0h exp %0h", $time, a, b); end end
module iso_engine_tb
  import iso_engine_pkg::*;
;
  logic CLK_I = 0, RST_I = 1, READ_I = 0, WRITE_I = 0, SI_START_I = 0, ACK_VALID_I = 0;
  logic ACK_DIR_IN_I = 0, ACK_DEFER_I = 0, TX_HAVE_I = 1, TX_LAST_I = 0, OUT_VALID_I = 0;
  logic OUT_CRC_OK_I = 1, OUT_ABORT_I = 0, OUT_MISSING_I = 0, OUT_LEN_OK_I = 1;
  logic OUT_DEFER_I = 0, OUT_BUF_RDY_I = 1, WAITREQUEST_O, TX_POP_O, DP_VALID_O;
  logic DP_READY_I, DP_LPF_O, DP_ZLP_O, OUT_ACCEPT_O, OUT_DISCARD_O;
  logic [BUS_AW-1:0]  ADDRESS_I = '0;
  logic [31:0]        WRITEDATA_I = '0, READDATA_O, q;
  logic [DADDR_W-1:0] ACK_ADDR_I = '0, OUT_ADDR_I = 7'h05;
  logic [EP_W-1:0]    ACK_EP_I = '0, OUT_EP_I = 4'h3;
  logic [SEQ_W-1:0]   ACK_SEQ_I = '0, OUT_SEQ_I = '0, DP_SEQ_O;
  logic [NUMP_W-1:0]  ACK_NUMP_I = '0;
  logic [TT_W-1:0]    ACK_TT_I = '0, OUT_TT_I = TT_ISO;
  logic [3:0]         stall = 4'h1;
  logic               host_bad;
  int                 n_errors = 0, samples_checked = 0, cyc = 0, pops = 0;
  iso_engine u_dut (.CLK_I, .RST_I, .ADDRESS_I, .READ_I, .WRITE_I, .WRITEDATA_I,
    .READDATA_O, .WAITREQUEST_O, .SI_START_I, .ACK_VALID_I, .ACK_ADDR_I, .ACK_EP_I,
    .ACK_DIR_IN_I, .ACK_SEQ_I, .ACK_NUMP_I, .ACK_DEFER_I, .ACK_TT_I, .TX_HAVE_I,
    .TX_LAST_I, .TX_POP_O, .DP_VALID_O, .DP_READY_I, .DP_SEQ_O, .DP_LPF_O, .DP_ZLP_O,
    .OUT_VALID_I, .OUT_ADDR_I, .OUT_EP_I, .OUT_SEQ_I, .OUT_CRC_OK_I, .OUT_ABORT_I,
    .OUT_MISSING_I, .OUT_LEN_OK_I, .OUT_DEFER_I, .OUT_TT_I, .OUT_BUF_RDY_I,
    .OUT_ACCEPT_O, .OUT_DISCARD_O);
  iso_link_model u_host (.clk_i(CLK_I), .rst_i(RST_I), .si_i(SI_START_I),
    .dp_valid_i(DP_VALID_O), .dp_seq_i(DP_SEQ_O), .dp_lpf_i(DP_LPF_O), .stall_i(stall),
    .dp_ready_o(DP_READY_I), .bad_o(host_bad));
  // consumed application packets, judged against the packets sent with data
  always @(posedge CLK_I) begin
    if (TX_POP_O === 1'b1) pops++;
  end
  always #10 CLK_I = ~CLK_I;
  // whole run needs well under a thousand cycles
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  task close_out;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // all drivers start just after a rising edge and end just after one
  task bus(input logic w, input logic [BUS_AW-1:0] a, input logic [31:0] d);
    READ_I <= !w; WRITE_I <= w; ADDRESS_I <= a; WRITEDATA_I <= d;
    // no cycle count assumed: only the bench timeout ends this wait
    do @(posedge CLK_I); while (WAITREQUEST_O !== 1'b0);
    q = READDATA_O;
    READ_I <= 0; WRITE_I <= 0;
    @(posedge CLK_I);
  endtask : bus
  task si;
    SI_START_I <= 1;
    @(posedge CLK_I); SI_START_I <= 0;
    @(posedge CLK_I);
  endtask : si
  // k selects the defect: 1 addr, 2 ep, 3 seq, 4 deferred, 5 direction, 6 type
  task ack(input int k, input logic [SEQ_W-1:0] s, input logic [NUMP_W-1:0] p);
    ACK_ADDR_I <= (k == 1) ? 7'h06 : 7'h05; ACK_EP_I <= (k == 2) ? 4'h2 : 4'h3;
    ACK_SEQ_I <= (k == 3) ? s + 5'h03 : s; ACK_NUMP_I <= p; ACK_DEFER_I <= (k == 4);
    ACK_DIR_IN_I <= (k != 5); ACK_TT_I <= (k == 6) ? 3'h2 : TT_ISO; ACK_VALID_I <= 1;
    @(posedge CLK_I); ACK_VALID_I <= 0;
    @(posedge CLK_I);
  endtask : ack
  task get_dp(input logic [SEQ_W-1:0] s, input logic l, input logic z);
    int n;
    n = 0;
    do begin @(posedge CLK_I); n++; end while (!(DP_VALID_O && DP_READY_I) && n < 60);
    `CHK(DP_SEQ_O, s)
    `CHK(DP_LPF_O, l)
    `CHK(DP_ZLP_O, z)
    `CHK(host_bad, 1'b0)
  endtask : get_dp
  task no_dp(input int n);
    repeat (n) begin @(posedge CLK_I); `CHK(DP_VALID_O, 1'b0) end
  endtask : no_dp
  // er bits: crc, length, abort, missing, deferred, type
  task out(input logic [SEQ_W-1:0] s, input logic [5:0] er, input logic b, input logic x);
    OUT_CRC_OK_I <= !er[0]; OUT_LEN_OK_I <= !er[1]; OUT_ABORT_I <= er[2];
    OUT_MISSING_I <= er[3]; OUT_DEFER_I <= er[4]; OUT_TT_I <= er[5] ? 3'h2 : TT_ISO;
    OUT_SEQ_I <= s; OUT_BUF_RDY_I <= b; OUT_VALID_I <= 1;
    @(posedge CLK_I); OUT_VALID_I <= 0;
    @(posedge CLK_I);
    `CHK(OUT_ACCEPT_O, x)
    `CHK(OUT_DISCARD_O, !x)
    `CHK(DP_VALID_O, 1'b0)
  endtask : out
  initial begin
    repeat (6) @(posedge CLK_I);
    RST_I <= 0;
    @(posedge CLK_I);
    bus(0, OFS_CTRL, 0); `CHK(q, 32'h0)
    bus(1, OFS_CTRL, 32'h0000_7985);
    bus(0, OFS_CTRL, 0); `CHK(q, 32'h0000_7985)
    bus(1, OFS_COUNT, '1);
    bus(0, OFS_COUNT, 0); `CHK(q, 32'h0)
    bus(0, 4'hc, 0); `CHK(q, 32'h0)
    $display("registers done");
    si; ack(0, 0, 2);
    get_dp(0, 0, 0);
    TX_LAST_I <= 1;
    get_dp(1, 1, 0);
    ack(0, 2, 1); no_dp(10);
    bus(0, OFS_STATUS, 0); `CHK(q, 32'h0008_0402)
    $display("in burst done");
    si; TX_HAVE_I <= 0; ack(0, 0, 2);
    get_dp(0, 1, 1);
    TX_HAVE_I <= 1;
    $display("empty reply done");
    si;
    for (int k = 1; k < 7; k++) ack(k, 0, 1);
    no_dp(6); ack(0, 0, 1);
    get_dp(0, 1, 0);
    $display("invalid ack done");
    // base speed: type field unchecked, host splits eleven packets as eight then three
    bus(1, OFS_CTRL, 32'h0000_1985);
    si; TX_LAST_I <= 0; ack(6, 0, 8);
    for (int i = 0; i < 11; i++) begin
      if (i == 8) ack(6, 8, 3);
      if (i == 10) TX_LAST_I <= 1;
      get_dp(i[4:0], i == 10, 0);
    end
    bus(1, OFS_CTRL, 32'h0000_7985);
    $display("base speed done");
    si; stall <= 4'h3; TX_LAST_I <= 0; ack(0, 0, 31); ack(0, 31, 2);
    for (int i = 0; i < 33; i++) begin
      if (i == 32) TX_LAST_I <= 1;
      get_dp(i[4:0], i == 32, 0);
    end
    $display("pipelined done");
    si; `CHK(pops, 47)
    `CHK(host_bad, 1'b0)
    out(0, 0, 1, 1);
    for (int i = 0; i < 6; i++) out(1, 6'h01 << i, 1, 0);
    out(1, 0, 0, 0); out(2, 0, 1, 1);
    out(5, 0, 1, 0); out(3, 0, 1, 0);
    si; out(0, 0, 1, 1);
    bus(0, OFS_COUNT, 0); `CHK(q, 32'h0009_0003)
    $display("out path done");
    close_out();
  end
endmodule : iso_engine_tb
bind iso_engine iso_engine_properties u_props (.CLK_I, .RST_I, .READ_I, .WRITE_I,
  .WAITREQUEST_O, .SI_START_I, .DP_VALID_O, .DP_READY_I, .DP_LPF_O, .DP_ZLP_O, .DP_SEQ_O,
  .TX_POP_O, .OUT_VALID_I, .OUT_CRC_OK_I, .OUT_LEN_OK_I, .OUT_ABORT_I, .OUT_MISSING_I,
  .OUT_DEFER_I, .OUT_BUF_RDY_I, .OUT_ACCEPT_O, .OUT_DISCARD_O);
`default_nettype wire
